// ### hw/apcc_map.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * converter power and coding control.
 * assumes a plain word-addressed register port with 8-bit byte addresses.
 */
`ifndef APCC_MAP_SVH
`define APCC_MAP_SVH

// ****************************************************************
// register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define APCC_CTRL_OFS 8'h00
`define APCC_STATUS_OFS 8'h04
`define APCC_RESULT_OFS 8'h08

// ****************************************************************
// control fields and reset value
// ****************************************************************
`define APCC_PM_LO_BIT 0
`define APCC_PM_HI_BIT 1
`define APCC_CTRL_RESET 2'h0

// ****************************************************************
// status fields
// ****************************************************************
`define APCC_ST_CORE_BIT 0
`define APCC_ST_REF_BIT 1
`define APCC_ST_BUSY_BIT 2
`define APCC_ST_RANGE_BIT 3
`define APCC_ST_SLEEP_BIT 4
`define APCC_ST_NAP_BIT 5
`define APCC_ST_OFF_BIT 6

// ****************************************************************
// result word shape, serial timing and pin reset levels
// ****************************************************************
`define APCC_RES_W 14
`define APCC_WORD_W 16
`define APCC_LEAD_ZEROS 2'h0
`define APCC_BIT_DIV 4
`define APCC_PIN_RESET 3'h5

`endif

// ### hw/apcc_pkg.sv
/*
 * types of the converter power and coding control: power states,
 * decoded power modes and the packed state of the top and the serialiser.
 * assumes apcc_map.svh is on the include path.
 */
package apcc_pkg;

   // ****************************************************************
   // power state and decoded mode
   // ****************************************************************
   typedef enum logic [1:0] {PS_RUN, PS_NAP, PS_OFF} apcc_pstate_t;
   typedef enum logic [1:0] {MD_NORMAL, MD_NAP_FULL, MD_OFF, MD_NAP_PART} apcc_mode_t;

   // ****************************************************************
   // top state
   // ****************************************************************
   typedef struct packed {
      logic [1:0] pm;
      apcc_pstate_t pst;
      logic cs_prev;
      logic range_lat;
      logic busy;
      logic core_on;
      logic ref_on;
      logic load;
      logic bit_en;
      logic [7:0] div;
      logic [15:0] word;
      logic [31:0] rdata;
   } apcc_state_t;

   // ****************************************************************
   // serialiser state
   // ****************************************************************
   typedef struct packed {
      logic [15:0] shreg;
      logic [4:0] left;
      logic sdout;
      logic valid;
   } apcc_shift_t;

endpackage : apcc_pkg

// ### hw/apcc_shift.sv
/*
 * serialiser for the 16-bit result word, most significant bit first, one
 * bit per bit_en pulse.
 * assumes load is a one-cycle pulse; a load during a shift restarts the word.
 */
`timescale 1ns/1ps
module apcc_shift
   import apcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // word in
   input wire logic load,
   input wire logic [15:0] word,
   input wire logic bit_en,
   // serial out
   output logic sdout,
   output logic valid
);
   apcc_shift_t r_reg, r_next;

   always_comb begin
      r_next = r_reg;
      if (load) begin
         r_next.shreg = word;
         r_next.left = 5'h10;
         r_next.valid = 1'b0;
      end else if (bit_en) begin
         if (r_reg.left != 5'h00) begin
            r_next.sdout = r_reg.shreg[15];
            r_next.shreg = {r_reg.shreg[14:0], 1'b0};
            r_next.left = r_reg.left - 5'h01;
            r_next.valid = 1'b1;
         end else begin
            r_next.sdout = 1'b0;
            r_next.valid = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sdout = r_reg.sdout;
   assign valid = r_reg.valid;

endmodule : apcc_shift

// ### hw/apcc_sync.sv
/*
 * two-stage synchroniser for a group of pin levels.
 * assumes the pins are asynchronous to CLK; only the second stage is read.
 */
`timescale 1ns/1ps
module apcc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pins in, synchronised levels out
   input wire logic [W-1:0] pin,
   output logic [W-1:0] lvl
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } apcc_sync_t;

   apcc_sync_t r_reg, r_next;

   if (W < 1) begin : g_bad_w
      $error("apcc_sync: W must be at least 1");
   end

   always_comb begin
      r_next.s1 = pin;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r_reg <= {RST_VAL, RST_VAL};
      end else begin
         r_reg <= r_next;
      end
   end

   assign lvl = r_reg.s2;

endmodule : apcc_sync

// ### hw/apcc_top.sv
/*
 * power-management and result-coding control of a 14-bit sampling converter:
 * control register, power-state sequencing, range latch and result word.
 * assumes the converter core runs on CLK, reports end of conversion with a
 * one-cycle CONV_DONE and gives its code in straight binary on SAR_CODE.
 */
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "apcc_map.svh"

module apcc_top
   import apcc_pkg::*;
#(
   parameter int BIT_DIV = `APCC_BIT_DIV
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // pins
   input wire logic SLEEP_N,
   input wire logic RANGE_SELECT,
   input wire logic CONVERT_START_N,
   // converter core
   input wire logic CONV_DONE,
   input wire logic [13:0] SAR_CODE,
   output logic BUSY,
   output logic CORE_ON,
   output logic REF_ON,
   // serial result
   output logic SDOUT,
   output logic SDOUT_VALID
);
   import apcc_pkg::*;

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (BIT_DIV < 1 || BIT_DIV > 255) begin : g_bad_div
      $error("apcc_top: BIT_DIV must lie in 1..255");
   end

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [2:0] pins_s;
   logic sleep_s;
   logic range_s;
   logic cs_s;

   apcc_sync #(.W(3), .RST_VAL(`APCC_PIN_RESET)) u_sync (
      .clk(CLK),
      .rst_b(RST_B),
      .pin({SLEEP_N, RANGE_SELECT, CONVERT_START_N}),
      .lvl(pins_s)
   );

   assign sleep_s = pins_s[2];
   assign range_s = pins_s[1];
   assign cs_s = pins_s[0];

   // ****************************************************************
   // state and decode
   // ****************************************************************
   apcc_state_t r_reg, r_next;
   apcc_mode_t mode;
   logic cs_fall;
   logic cs_rise;
   logic start;
   logic done;
   logic napping_mode;
   logic [7:0] div_last;

   assign div_last = 8'(BIT_DIV - 1);
   assign cs_fall = r_reg.cs_prev & ~cs_s;
   assign cs_rise = ~r_reg.cs_prev & cs_s;
   assign start = cs_rise && r_reg.pst == PS_RUN && !r_reg.busy;
   assign done = r_reg.busy && CONV_DONE;
   assign napping_mode = mode == MD_NAP_FULL || mode == MD_NAP_PART;

   // software-only control relies on the host holding sleep high
   always_comb begin
      case (r_reg.pm)
         2'b00: mode = sleep_s ? MD_NORMAL : MD_NAP_FULL;
         2'b01: mode = MD_NAP_FULL;
         2'b10: mode = MD_OFF;
         2'b11: mode = MD_NAP_PART;
         default: mode = MD_NORMAL;
      endcase
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      r_next = r_reg;
      r_next.cs_prev = cs_s;
      r_next.load = 1'b0;
      r_next.rdata = '0;

      // register writes
      if (WR && ADDR == `APCC_CTRL_OFS) begin
         r_next.pm = {WDATA[`APCC_PM_HI_BIT], WDATA[`APCC_PM_LO_BIT]};
      end

      // register reads, data in the following cycle only
      if (RD) begin
         case (ADDR)
            `APCC_CTRL_OFS: r_next.rdata = {30'h0, r_reg.pm};
            `APCC_STATUS_OFS: begin
               r_next.rdata[`APCC_ST_CORE_BIT] = r_reg.core_on;
               r_next.rdata[`APCC_ST_REF_BIT] = r_reg.ref_on;
               r_next.rdata[`APCC_ST_BUSY_BIT] = r_reg.busy;
               r_next.rdata[`APCC_ST_RANGE_BIT] = r_reg.range_lat;
               r_next.rdata[`APCC_ST_SLEEP_BIT] = sleep_s;
               r_next.rdata[`APCC_ST_NAP_BIT] = r_reg.pst == PS_NAP;
               r_next.rdata[`APCC_ST_OFF_BIT] = r_reg.pst == PS_OFF;
            end
            `APCC_RESULT_OFS: r_next.rdata = {16'h0, r_reg.word};
            default: r_next.rdata = '0;
         endcase
      end

      // sample instant: hold mode starts, range frozen for this result
      if (start) begin
         r_next.busy = 1'b1;
         r_next.range_lat = range_s;
      end

      // end of conversion: code the result and hand it to the serialiser
      if (done) begin
         r_next.busy = 1'b0;
         r_next.load = 1'b1;
         if (r_reg.range_lat) begin
            r_next.word = {`APCC_LEAD_ZEROS, ~SAR_CODE[13], SAR_CODE[12:0]};
         end else begin
            r_next.word = {`APCC_LEAD_ZEROS, SAR_CODE};
         end
      end

      // power sequencing
      case (r_reg.pst)
         PS_RUN: begin
            if (mode == MD_OFF) begin
               r_next.pst = PS_OFF;
            end else if (done && napping_mode) begin
               r_next.pst = PS_NAP;
            end
         end
         PS_NAP: begin
            // the wake edge leaves the host its 5 us low time to settle
            if (mode == MD_OFF) begin
               r_next.pst = PS_OFF;
            end else if (mode == MD_NORMAL || cs_fall) begin
               r_next.pst = PS_RUN;
            end
         end
         PS_OFF: begin
            if (mode != MD_OFF) begin
               r_next.pst = PS_RUN;
            end
         end
         default: r_next.pst = PS_RUN;
      endcase

      // a conversion cut short by power-down is abandoned
      if (r_next.pst != PS_RUN) begin
         r_next.busy = 1'b0;
      end
      r_next.core_on = r_next.pst == PS_RUN;
      r_next.ref_on = r_next.pst == PS_RUN || (r_next.pst == PS_NAP && mode == MD_NAP_PART);

      // serial bit-rate enable
      r_next.bit_en = 1'b0;
      if (r_reg.div >= div_last) begin
         r_next.div = '0;
         r_next.bit_en = 1'b1;
      end else begin
         r_next.div = r_reg.div + 8'h01;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         r_reg <= '0;
         r_reg.pm <= `APCC_CTRL_RESET;
         r_reg.pst <= PS_RUN;
         r_reg.cs_prev <= 1'b1;
         r_reg.core_on <= 1'b1;
         r_reg.ref_on <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ****************************************************************
   // serial result output
   // ****************************************************************
   apcc_shift u_shift (
      .clk(CLK),
      .rst_b(RST_B),
      .load(r_reg.load),
      .word(r_reg.word),
      .bit_en(r_reg.bit_en),
      .sdout(SDOUT),
      .valid(SDOUT_VALID)
   );

   assign RDATA = r_reg.rdata;
   assign BUSY = r_reg.busy;
   assign CORE_ON = r_reg.core_on;
   assign REF_ON = r_reg.ref_on;

   // ****************************************************************
   // assertions
   // ****************************************************************
   logic seen_reg;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         seen_reg <= 1'b0;
      end else begin
         seen_reg <= 1'b1;
      end
   end

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);

   property p_range_latch;
      start |=> (r_reg.range_lat == $past(range_s)) && r_reg.busy;
   endproperty
   a_range_latch: assert property (p_range_latch) else $error("range not latched at sample");

   property p_unipolar;
      (done && !r_reg.range_lat) |=> r_reg.word == {2'b00, $past(SAR_CODE)} ##1 r_reg.word[15:14] == 2'b00;
   endproperty
   a_unipolar: assert property (p_unipolar) else $error("unipolar word wrong");

   property p_bipolar;
      (done && r_reg.range_lat) |=> r_reg.word == {2'b00, ~$past(SAR_CODE[13]), $past(SAR_CODE[12:0])};
   endproperty
   a_bipolar: assert property (p_bipolar) else $error("bipolar word wrong");

   property p_full_off;
      r_reg.pst == PS_OFF |-> !r_reg.core_on && !r_reg.ref_on;
   endproperty
   a_full_off: assert property (p_full_off) else $error("circuits on in full power-down");

   property p_partial;
      (r_next.pst == PS_NAP && mode == MD_NAP_PART) |=> r_reg.ref_on && !r_reg.core_on;
   endproperty
   a_partial: assert property (p_partial) else $error("partial nap power wrong");

   property p_reset_bits;
      !seen_reg |-> r_reg.pm == 2'b00 && r_reg.pst == PS_RUN;
   endproperty
   a_reset_bits: assert property (p_reset_bits) else $error("power bits not zero after reset");

   property p_normal;
      (r_reg.pm == 2'b00 && sleep_s && r_reg.pst == PS_RUN && !WR) |=> r_reg.pst == PS_RUN && r_reg.core_on;
   endproperty
   a_normal: assert property (p_normal) else $error("powered down in normal mode");

   property p_nap_entry;
      (done && napping_mode) |=> r_reg.pst == PS_NAP && !r_reg.core_on && !r_reg.busy;
   endproperty
   a_nap_entry: assert property (p_nap_entry) else $error("no nap after conversion");

   property p_pm_one;
      (r_reg.pm == 2'b01 && done) |=> r_reg.pst == PS_NAP;
   endproperty
   a_pm_one: assert property (p_pm_one) else $error("bits 01 did not nap");

   property p_hold_off;
      r_reg.pm == 2'b10 |=> r_reg.pst == PS_OFF ##1 (r_reg.pst == PS_OFF || $past(WR, 2));
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("bits 10 left power-down");

   property p_wake;
      (r_reg.pst == PS_NAP && cs_fall && napping_mode) |=> r_reg.pst == PS_RUN && r_reg.core_on && r_reg.ref_on;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on convert-start fall");

   property p_lead_zeros;
      r_reg.load |-> ##[1:255] SDOUT_VALID && !SDOUT;
   endproperty
   a_lead_zeros: assert property (p_lead_zeros) else $error("serial word lacks leading zero");

endmodule : apcc_top

// ### verif/adc_power_and_coding_control_bench.sv
/*
 * self-checking bench of the converter power and coding control.
 * assumes apcc_top, apcc_core_model and apcc_map.svh; 100 MHz clock.
 */
`timescale 1ns/1ps
`include "apcc_map.svh"
module adc_power_and_coding_control_bench;
   import apcc_pkg::*;
   // ****************************************************************
   // signals
   // ****************************************************************
   localparam int BDIV = 2;
   localparam int LOW_CYC = 500;
   logic CLK = 1'b0, RST_B = 1'b0, WR = 1'b0, RD = 1'b0;
   logic SLEEP_N = 1'b1, RANGE_SELECT = 1'b0, CONVERT_START_N = 1'b1;
   logic [7:0] ADDR = 8'h0;
   logic [31:0] WDATA = 32'h0, RDATA, d;
   logic CONV_DONE, BUSY, CORE_ON, REF_ON, SDOUT, SDOUT_VALID;
   logic [13:0] SAR_CODE, code = 14'h0, c;
   logic [3:0] extra = 4'h0;
   logic [1:0] pm;
   logic sl, nap;
   int miscompares = 0, num_checks = 0;
   always #5 CLK = ~CLK;
   apcc_top #(.BIT_DIV(BDIV)) apcc_top_i (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .SLEEP_N(SLEEP_N), .RANGE_SELECT(RANGE_SELECT), .CONVERT_START_N(CONVERT_START_N),
      .CONV_DONE(CONV_DONE), .SAR_CODE(SAR_CODE), .BUSY(BUSY), .CORE_ON(CORE_ON), .REF_ON(REF_ON),
      .SDOUT(SDOUT), .SDOUT_VALID(SDOUT_VALID));
   apcc_core_model apcc_core_model_i (.clk(CLK), .rst_b(RST_B), .busy(BUSY), .code_in(code), .extra(extra),
      .conv_done(CONV_DONE), .sar_code(SAR_CODE));
   // ****************************************************************
   // checking and bus tasks
   // ****************************************************************
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wait_sig(input bit valid_sel, input logic v);
      int n;
      n = 0;
      while ((valid_sel ? SDOUT_VALID : BUSY) !== v) begin
         @(posedge CLK);
         #1;
         n++;
         if (n > 100) begin
            chk(32'h0, 32'h1, "timeout");
            report_and_stop();
         end
      end
   endtask : wait_sig
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 v = RDATA;
   endtask : reg_rd
   // ****************************************************************
   // expectations
   // ****************************************************************
   function automatic logic [15:0] exp_word(input logic [13:0] k, input logic r);
      return {2'b00, r ? {~k[13], k[12:0]} : k};
   endfunction : exp_word
   function automatic logic [1:0] exp_pwr(input logic [1:0] p, input logic s);
      // {core, ref} once a conversion has ended
      case (p)
         2'b00: return s ? 2'b11 : 2'b00;
         2'b11: return 2'b01;
         default: return 2'b00;
      endcase
   endfunction : exp_pwr
   // ****************************************************************
   // one conversion: start pulse, serial word, result and power levels
   // ****************************************************************
   task automatic convert(input logic [13:0] k, input logic r, input logic napped);
      logic [15:0] w;
      logic [31:0] v;
      logic [1:0] e;
      @(posedge CLK);
      code <= k;
      extra <= 4'($urandom_range(0, 15));
      RANGE_SELECT <= r;
      CONVERT_START_N <= 1'b0;
      repeat (4) @(posedge CLK);
      #1 chk(32'({CORE_ON, REF_ON}), 32'h3, "wake");
      // long low phase gives the reference time to settle before sampling
      repeat (napped ? LOW_CYC - 4 : 2) @(posedge CLK);
      CONVERT_START_N <= 1'b1;
      wait_sig(1'b0, 1'b1);
      @(posedge CLK);
      RANGE_SELECT <= ~r;
      wait_sig(1'b1, 1'b1);
      w[15] = SDOUT;
      for (int i = 14; i >= 0; i--) begin
         repeat (BDIV) @(posedge CLK);
         #1 w[i] = SDOUT;
      end
      chk(32'(w), 32'(exp_word(k, r)), "serial word");
      repeat (BDIV) @(posedge CLK);
      #1 chk(32'(SDOUT_VALID), 32'h0, "valid after word");
      chk(32'({BUSY, CORE_ON, REF_ON}), 32'(exp_pwr(pm, sl)), "power after done");
      reg_rd(`APCC_RESULT_OFS, v);
      chk(v & 32'hffff, 32'(exp_word(k, r)), "result reg");
      e = exp_pwr(pm, sl);
      reg_rd(`APCC_STATUS_OFS, v);
      chk(v & 32'h7f, 32'({1'b0, nap, sl, r, 1'b0, e[0], e[1]}), "status after done");
   endtask : convert
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'h2d16));
      repeat (5) @(posedge CLK);
      RST_B <= 1'b1;
      #1 chk(32'({BUSY, CORE_ON, REF_ON, SDOUT_VALID}), 32'h6, "reset pins");
      reg_rd(`APCC_CTRL_OFS, d);
      chk(d, 32'h0, "ctrl reset");
      @(posedge CLK);
      #1 chk(RDATA, 32'h0, "rdata one cycle");
      reg_rd(`APCC_STATUS_OFS, d);
      chk(d & 32'h7f, 32'h13, "status reset");
      reg_wr(`APCC_STATUS_OFS, 32'hffff_ffff);
      reg_rd(8'h3c, d);
      chk(d, 32'h0, "unmapped read");
      reg_rd(`APCC_CTRL_OFS, d);
      chk(d, 32'h0, "status write ignored");
      for (int m = 0; m < 5; m++) begin
         pm = (m < 2) ? 2'b00 : ((m == 3) ? 2'b11 : 2'b01);
         sl = (m == 1 || m == 4) ? 1'b0 : 1'b1;
         nap = !(pm == 2'b00 && sl);
         reg_wr(`APCC_CTRL_OFS, 32'h0);
         SLEEP_N <= 1'b1;
         repeat (4) @(posedge CLK);
         reg_wr(`APCC_CTRL_OFS, 32'(pm));
         SLEEP_N <= sl;
         repeat (3) @(posedge CLK);
         for (int k = 0; k < 3; k++) begin
            c = (k == 0) ? ((m[0]) ? 14'h2000 : 14'h1fff) : ((k == 1 && m > 2) ? 14'h3fff : 14'($urandom));
            convert(c, (k == 0) ? m[1] : 1'($urandom), nap && k > 0);
         end
      end
      reg_wr(`APCC_CTRL_OFS, 32'h2);
      SLEEP_N <= 1'b1;
      repeat (2) @(posedge CLK);
      #1 chk(32'({CORE_ON, REF_ON}), 32'h0, "full off");
      @(posedge CLK);
      CONVERT_START_N <= 1'b0;
      repeat (4) @(posedge CLK);
      CONVERT_START_N <= 1'b1;
      repeat (8) @(posedge CLK);
      #1 chk(32'({BUSY, CORE_ON, REF_ON}), 32'h0, "off ignores start");
      reg_rd(`APCC_STATUS_OFS, d);
      chk(d & 32'h43, 32'h40, "status off");
      reg_wr(`APCC_CTRL_OFS, 32'h0);
      repeat (3) @(posedge CLK);
      #1 chk(32'({CORE_ON, REF_ON}), 32'h3, "back to run");
      report_and_stop();
   end
   initial begin
      repeat (90000) @(posedge CLK);
      chk(32'h0, 32'h1, "watchdog");
      report_and_stop();
   end
endmodule : adc_power_and_coding_control_bench

// ### verif/apcc_core_model.sv
/*
 * behavioural model of the converter core behind the power and coding control.
 * assumes busy rises at the sample instant; answers after LAT plus extra cycles.
 */
`timescale 1ns/1ps
module apcc_core_model #(
   parameter int LAT = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // conversion handshake
   input wire logic busy,
   input wire logic [13:0] code_in,
   input wire logic [3:0] extra,
   output logic conv_done,
   output logic [13:0] sar_code
);
   // ****************************************************************
   // conversion timer
   // ****************************************************************
   int cnt;
   logic busy_d;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         busy_d <= 1'b0;
         conv_done <= 1'b0;
         sar_code <= 14'h0;
      end else begin
         busy_d <= busy;
         conv_done <= 1'b0;
         // code is not held outside the done pulse, so a late read shows garbage
         sar_code <= ~sar_code;
         if (!busy) begin
            cnt <= 0;
         end else if (!busy_d) begin
            cnt <= LAT + int'(extra);
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end else if (cnt == 1) begin
            cnt <= 0;
            conv_done <= 1'b1;
            sar_code <= code_in;
         end
      end
   end
endmodule : apcc_core_model
